// ---- rpr_checker.sv ----
// Concurrent checks on the power and reset control ports
`timescale 1ns/1ns
module rpr_checker (
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire rpr_pkg::rpr_req_t host_req,
    input wire rpr_pkg::rpr_rsp_t host_rsp,
    input wire logic [7:0]        pin_in_clean,
    input wire logic [7:0]        pin_out,
    input wire logic              osc_enable,
    input wire logic              core_active,
    input wire logic              hard_soft_sleep_request_bit,
    input wire logic              host_ready,
    input wire logic              driver1_on,
    input wire logic              driver2_on,
    input wire logic              tx_soft_sleep_request_bit
);
    logic [10:0] up_cnt;
    logic [10:0] slp_cnt;
    wire         sleep_wr = host_req.valid && host_req.write
                            && host_req.wdata[rpr_pkg::SLEEP_BIT]
                            && host_req.addr == rpr_pkg::ADR_CMD;
    // Saturating counts, so a long run cannot wrap them into a false pass
    always_ff @(posedge ref_clk) begin
        up_cnt  <= hard_soft_sleep_request_bit ? 11'h000 : up_cnt + {10'h000, ~&up_cnt};
        slp_cnt <= (core_active || hard_soft_sleep_request_bit) ? 11'h000 : slp_cnt + {10'h000, ~&slp_cnt};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    osc_off_a: assert property (hard_soft_sleep_request_bit |-> !osc_enable && !core_active)
        else $error("clock or core running in hard power-down");
    input_clamp_a: assert property ($past(hard_soft_sleep_request_bit) && hard_soft_sleep_request_bit
        |-> pin_in_clean == 8'h00) else $error("inputs not clamped in hard power-down");
    hard_freeze_a: assert property ($past(hard_soft_sleep_request_bit) && hard_soft_sleep_request_bit
        |-> $stable(pin_out)) else $error("outputs moved in hard power-down");
    soft_freeze_a: assert property ($past(!core_active) && !core_active
        |-> $stable(pin_out)) else $error("outputs moved in soft power-down");
    sleep_entry_a: assert property (sleep_wr && host_ready && core_active
        |-> ##[1:2] !core_active) else $error("sleep request not obeyed");
    wake_delay_a: assert property ($rose(core_active)
        |-> up_cnt < 11'h004 || slp_cnt >= 11'h3FC) else $error("wake before exit delay");
    start_delay_a: assert property ($rose(host_ready) |-> up_cnt >= 11'h3FC)
        else $error("host access before start-up delay");
    tx_off_a: assert property (!(driver1_on && driver2_on) |-> tx_soft_sleep_request_bit)
        else $error("transmitter on with a driver disabled");
    rsp_cause_a: assert property (host_rsp.valid
        |-> $past(host_req.valid && !host_req.write && !hard_soft_sleep_request_bit))
        else $error("answer without an accepted read");
    cover property (sleep_wr && core_active ##2 !core_active);
    cover property ($rose(core_active) && up_cnt > 11'h004);
    cover property ($fell(host_ready));
endmodule // rpr_checker

bind rpr_power_reset_control rpr_checker chk_u (.ref_clk, .reset_n, .host_req, .host_rsp,
    .pin_in_clean, .pin_out, .osc_enable, .core_active, .hard_soft_sleep_request_bit, .host_ready,
    .driver1_on, .driver2_on, .tx_soft_sleep_request_bit);

// ---- rpr_host_model.sv ----
// Host controller model: register accesses and the reset pin
`timescale 1ns/1ns
module rpr_host_model (
    input  wire logic              ref_clk,
    output rpr_pkg::rpr_req_t      host_req,
    input  wire rpr_pkg::rpr_rsp_t host_rsp,
    output logic                   reset_soft_sleep_request_bit_pin
);
    logic [7:0] rd_val;
    logic       rd_ok;
    initial begin
        host_req = '0;
        reset_soft_sleep_request_bit_pin = 1'h1;
    end
    // One access; idle address and data are inverted so stale values never help
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        host_req <= {1'h1, w, a, d};
        @(posedge ref_clk);
        host_req <= {1'h0, w, ~a, ~d};
        @(posedge ref_clk);
        // Answer still stands at this edge; its update is not yet applied
        rd_ok = host_rsp.valid;
        rd_val = host_rsp.rdata;
    endtask
    // Reads address zero until it answers; bounded in case it never does
    task automatic poll(output int n);
        n = 0;
        acc(1'h1, rpr_pkg::ADR_ZERO, 8'h55);
        rd_ok = 1'h0;
        while (!rd_ok && n < 1500) begin
            acc(1'h0, rpr_pkg::ADR_ZERO, 8'h00);
            n++;
        end
    endtask
    // Pin level changes at once through a nonblocking write, with no wait for a clock edge
    task automatic pin(input logic lvl);
        reset_soft_sleep_request_bit_pin <= lvl;
    endtask
endmodule // rpr_host_model

// ---- rpr_pkg.sv ----
// Constants and types for the reader power and reset control block
package rpr_pkg;

    // ***************************************************************
    // Clock and timing
    // ***************************************************************
    localparam int CLK_MHZ        = 250;
    localparam int SPIKE_NS       = 10;
    localparam int SPIKE_CYC      = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int STARTUP_CLOCKS = 1024;
    localparam int WAKE_CLOCKS    = 1024;
    localparam int CNT_W          = 11;

    // ***************************************************************
    // Register offsets and fields
    // ***************************************************************
    localparam logic [5:0] ADR_ZERO = 6'h00;
    localparam logic [5:0] ADR_CMD  = 6'h01;
    localparam logic [5:0] ADR_IEN  = 6'h02;
    localparam logic [5:0] ADR_STAT = 6'h07;
    localparam logic [5:0] ADR_LVL  = 6'h0A;
    localparam logic [5:0] ADR_TXC  = 6'h14;
    localparam int SLEEP_BIT  = 4;
    localparam int CKSUM_BIT  = 5;
    localparam int FLUSH_BIT  = 7;
    localparam int DRV1_BIT   = 0;
    localparam int DRV2_BIT   = 1;
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [7:0] IEN_RST  = 8'h80;
    localparam logic [1:0] TXC_RST  = 2'h0;
    localparam logic [7:0] ZERO_REG = 8'h00;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_HARD  = 3'b000,
        ST_START = 3'b001,
        ST_RUN   = 3'b010,
        ST_SLEEP = 3'b011,
        ST_EXIT  = 3'b100
    } rpr_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rpr_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } rpr_rsp_t;

endpackage

// ---- rpr_power_reset_control.sv ----
// Power-down, reset filtering, start-up delay and control registers of the reader
`timescale 1ns/1ns
module rpr_power_reset_control (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              reset_soft_sleep_request_bit_pin,
    input  wire rpr_pkg::rpr_req_t host_req,
    output rpr_pkg::rpr_rsp_t      host_rsp,
    input  wire logic              cmd_done,
    input  wire logic              checksum_done_flag,
    input  wire logic [7:0]        pin_in,
    input  wire logic [7:0]        pin_out_req,
    output logic [7:0]             pin_out,
    output logic [7:0]             pin_in_clean,
    output logic                   osc_enable,
    output logic                   core_active,
    output logic                   hard_soft_sleep_request_bit,
    output logic                   host_ready,
    output logic                   driver1_on,
    output logic                   driver2_on,
    output logic                   tx_soft_sleep_request_bit,
    output logic [3:0]             command_code,
    output logic [7:0]             irq_enable,
    output logic                   fifo_flush
);

    // ***************************************************************
    // Reset pin synchroniser and spike filter
    // ***************************************************************
    logic       rst_meta;
    logic       rst_sync;
    logic [1:0] spike_cnt;
    logic       pin_low;
    logic [7:0] in_meta;
    logic [7:0] in_sync;

    // Two stages before anything looks at the pin
    always_ff @(posedge ref_clk) begin
        rst_meta <= reset_soft_sleep_request_bit_pin;
        rst_sync <= rst_meta;
        in_meta  <= pin_in;
        in_sync  <= in_meta;
    end

    // Low must persist SPIKE_CYC cycles; high releases at once so a short
    // glitch high during power-down already moves the part into ST_START
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            spike_cnt <= 2'h0;
            pin_low   <= 1'b0;
        end else if (rst_sync) begin
            spike_cnt <= 2'h0;
            pin_low   <= 1'b0;
        end else if (spike_cnt == 2'(rpr_pkg::SPIKE_CYC - 1)) begin
            pin_low   <= 1'b1;
        end else begin
            spike_cnt <= spike_cnt + 2'h1;
        end
    end

    // ***************************************************************
    // Power state machine
    // ***************************************************************
    rpr_pkg::rpr_state_t      state;
    rpr_pkg::rpr_state_t      next_state;
    logic [rpr_pkg::CNT_W-1:0] cnt;
    logic [rpr_pkg::CNT_W-1:0] next_cnt;
    logic                      sleep_bit;
    logic                      host_ok;
    logic                      wr;
    logic                      rd;
    logic                      wr_cmd;
    logic                      sleep_wr1;
    logic                      sleep_wr0;
    logic                      cnt_end_start;
    logic                      cnt_end_wake;
    logic                      quiet;

    // Host traffic is honoured only once the part is up
    assign host_ok   = (state != rpr_pkg::ST_HARD) && (state != rpr_pkg::ST_START);
    assign wr        = host_req.valid && host_req.write && host_ok;
    assign rd        = host_req.valid && !host_req.write && host_ok;
    assign wr_cmd    = wr && (host_req.addr == rpr_pkg::ADR_CMD);
    assign sleep_wr1 = wr_cmd && host_req.wdata[rpr_pkg::SLEEP_BIT];
    assign sleep_wr0 = wr_cmd && !host_req.wdata[rpr_pkg::SLEEP_BIT];
    assign cnt_end_start = cnt == rpr_pkg::CNT_W'(rpr_pkg::STARTUP_CLOCKS - 1);
    assign cnt_end_wake  = cnt == rpr_pkg::CNT_W'(rpr_pkg::WAKE_CLOCKS - 1);
    // Sleeping or waking counts as powered down for the core and outputs
    assign quiet = (state == rpr_pkg::ST_SLEEP) || (state == rpr_pkg::ST_EXIT);

    // Next state; a new sleep request during the exit wait restarts sleep
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            rpr_pkg::ST_HARD: begin
                next_cnt = '0;
                if (!pin_low) begin
                    next_state = rpr_pkg::ST_START;
                end
            end
            rpr_pkg::ST_START: begin
                next_cnt = cnt + 1'b1;
                if (cnt_end_start) begin
                    next_state = rpr_pkg::ST_RUN;
                    next_cnt   = '0;
                end
            end
            rpr_pkg::ST_RUN: begin
                if (sleep_wr1) begin
                    next_state = rpr_pkg::ST_SLEEP;
                end
            end
            rpr_pkg::ST_SLEEP: begin
                next_cnt = '0;
                if (sleep_wr0) begin
                    next_state = rpr_pkg::ST_EXIT;
                end
            end
            rpr_pkg::ST_EXIT: begin
                next_cnt = cnt + 1'b1;
                if (sleep_wr1) begin
                    next_state = rpr_pkg::ST_SLEEP;
                    next_cnt   = '0;
                end else if (cnt_end_wake) begin
                    next_state = rpr_pkg::ST_RUN;
                    next_cnt   = '0;
                end
            end
            default: begin
                next_state = rpr_pkg::ST_HARD;
                next_cnt   = '0;
            end
        endcase
    end

    // Pin low overrides every other state
    always_ff @(posedge ref_clk) begin
        if (!reset_n || pin_low) begin
            state <= rpr_pkg::ST_HARD;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ***************************************************************
    // Host registers
    // ***************************************************************
    logic [3:0] cmd_reg;
    logic [7:0] ien_reg;
    logic [1:0] txc_reg;
    logic [7:0] cmd_rd;
    logic [7:0] stat_rd;
    logic [7:0] txc_rd;
    logic [7:0] rd_mux;
    logic       wr_ien;
    logic       wr_txc;
    logic       wr_lvl;

    assign wr_ien = wr && (host_req.addr == rpr_pkg::ADR_IEN);
    assign wr_txc = wr && (host_req.addr == rpr_pkg::ADR_TXC);
    assign wr_lvl = wr && (host_req.addr == rpr_pkg::ADR_LVL);
    // Sleep bit stays set through the whole exit wait
    assign sleep_bit = quiet;
    assign cmd_rd  = {3'h0, sleep_bit, cmd_reg};
    assign stat_rd = 8'(checksum_done_flag) << rpr_pkg::CKSUM_BIT;
    assign txc_rd  = {6'h0, txc_reg};

    // Unmapped and reserved addresses read zero; flush bit is write-only
    assign rd_mux = (host_req.addr == rpr_pkg::ADR_CMD)  ? cmd_rd  :
                    (host_req.addr == rpr_pkg::ADR_IEN)  ? ien_reg :
                    (host_req.addr == rpr_pkg::ADR_STAT) ? stat_rd :
                    (host_req.addr == rpr_pkg::ADR_TXC)  ? txc_rd  :
                    rpr_pkg::ZERO_REG;

    // Command field: host write wins over completion since a completion in
    // the same cycle belongs to the command being replaced
    always_ff @(posedge ref_clk) begin
        if (!reset_n || pin_low) begin
            cmd_reg <= rpr_pkg::CMD_IDLE;
        end else if (wr_cmd) begin
            cmd_reg <= host_req.wdata[3:0];
        end else if (cmd_done && !quiet) begin
            cmd_reg <= rpr_pkg::CMD_IDLE;
        end
    end

    // Control-only registers: no internal writer exists, so sleep keeps them
    always_ff @(posedge ref_clk) begin
        if (!reset_n || pin_low) begin
            ien_reg <= rpr_pkg::IEN_RST;
            txc_reg <= rpr_pkg::TXC_RST;
        end else begin
            if (wr_ien) begin
                ien_reg <= host_req.wdata;
            end
            if (wr_txc) begin
                txc_reg <= host_req.wdata[1:0];
            end
        end
    end

    // Read answer one cycle after the request; writes never answer
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            host_rsp   <= '0;
            fifo_flush <= 1'b0;
        end else begin
            host_rsp.valid <= rd;
            host_rsp.rdata <= rd ? rd_mux : rpr_pkg::ZERO_REG;
            fifo_flush     <= wr_lvl && host_req.wdata[rpr_pkg::FLUSH_BIT];
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    logic hold_out;
    logic run_now;

    assign hold_out = pin_low || (state == rpr_pkg::ST_HARD) || quiet;
    assign run_now  = !pin_low && (state == rpr_pkg::ST_RUN || state == rpr_pkg::ST_START);

    // Pins freeze in either power-down; inputs are clamped only in hard mode
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pin_out      <= 8'h00;
            pin_in_clean <= 8'h00;
        end else begin
            if (!hold_out) begin
                pin_out <= pin_out_req;
            end
            if (pin_low || state == rpr_pkg::ST_HARD) begin
                pin_in_clean <= 8'h00;
            end else begin
                pin_in_clean <= in_sync;
            end
        end
    end

    // Power and transmitter status
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            osc_enable     <= 1'b0;
            core_active    <= 1'b0;
            hard_soft_sleep_request_bit <= 1'b1;
            host_ready     <= 1'b0;
            driver1_on     <= 1'b0;
            driver2_on     <= 1'b0;
            tx_soft_sleep_request_bit   <= 1'b1;
            command_code   <= rpr_pkg::CMD_IDLE;
            irq_enable     <= rpr_pkg::IEN_RST;
        end else begin
            osc_enable     <= !pin_low && state != rpr_pkg::ST_HARD;
            core_active    <= run_now;
            hard_soft_sleep_request_bit <= pin_low || state == rpr_pkg::ST_HARD;
            host_ready     <= !pin_low && host_ok;
            driver1_on     <= run_now && txc_reg[rpr_pkg::DRV1_BIT];
            driver2_on     <= run_now && txc_reg[rpr_pkg::DRV2_BIT];
            tx_soft_sleep_request_bit   <= !(run_now && (&txc_reg));
            command_code   <= cmd_reg;
            irq_enable     <= ien_reg;
        end
    end

endmodule // rpr_power_reset_control

// ---- tb_top.sv ----
// Self-checking bench for the power and reset control block
`timescale 1ns/1ns
module tb_top;
    logic              ref_clk = 1'h0;
    logic              reset_n = 1'h0;
    logic              cmd_done = 1'h0;
    logic              checksum_done_flag = 1'h0;
    logic [7:0]        pin_in = 8'h00;
    logic [7:0]        pin_out_req = 8'h00;
    rpr_pkg::rpr_req_t host_req;
    rpr_pkg::rpr_rsp_t host_rsp;
    logic              reset_soft_sleep_request_bit_pin;
    logic [7:0]        pin_out, pin_in_clean, irq_enable, v, snap, mdl_ien;
    logic [3:0]        command_code;
    logic              osc_enable, core_active, hard_soft_sleep_request_bit, host_ready;
    logic              driver1_on, driver2_on, tx_soft_sleep_request_bit, fifo_flush;
    logic [31:0]       rs = 32'h0000002F;
    int                err_total = 0;
    int                checks_done = 0;
    int                n;
    always #2 ref_clk = ~ref_clk;
    rpr_power_reset_control dut_u (.ref_clk, .reset_n, .reset_soft_sleep_request_bit_pin, .host_req,
        .host_rsp, .cmd_done, .checksum_done_flag, .pin_in, .pin_out_req, .pin_out,
        .pin_in_clean, .osc_enable, .core_active, .hard_soft_sleep_request_bit, .host_ready, .driver1_on,
        .driver2_on, .tx_soft_sleep_request_bit, .command_code, .irq_enable, .fifo_flush);
    rpr_host_model host_u (.ref_clk, .host_req, .host_rsp, .reset_soft_sleep_request_bit_pin);
    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // A read must answer, and with the expected byte
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        host_u.acc(1'h0, a, 8'h00);
        chk({host_u.rd_ok, host_u.rd_val}, {1'h1, e});
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host_u.acc(1'h1, a, d);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A used-up wait counts as a mismatch and ends the run
    task automatic tmo(input logic bad);
        if (bad) begin
            err_total++;
            conclude();
        end
    endtask
    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'h1;
        host_u.poll(n);
        tmo(!host_u.rd_ok);
        chk(2 * n >= 1020, 1);
        chk(host_u.rd_val, 8'h00);
        rd_chk(rpr_pkg::ADR_IEN, rpr_pkg::IEN_RST);
        rd_chk(rpr_pkg::ADR_TXC, 8'h00);
        pin_in <= rnd();
        repeat (4) @(posedge ref_clk);
        chk(pin_in_clean, pin_in);
        repeat (6) begin
            mdl_ien = rnd();
            wr(rpr_pkg::ADR_IEN, mdl_ien);
            rd_chk(rpr_pkg::ADR_IEN, mdl_ien);
        end
        wr(rpr_pkg::ADR_CMD, 8'h0C);
        rd_chk(rpr_pkg::ADR_CMD, 8'h0C);
        chk(command_code, 4'hC);
        cmd_done <= 1'h1;
        @(posedge ref_clk);
        cmd_done <= 1'h0;
        rd_chk(rpr_pkg::ADR_CMD, 8'h00);
        checksum_done_flag <= 1'h1;
        wr(rpr_pkg::ADR_STAT, 8'h00);
        rd_chk(rpr_pkg::ADR_STAT, 8'h20);
        wr(rpr_pkg::ADR_LVL, 8'h80);
        chk(fifo_flush, 1'h1);
        rd_chk(rpr_pkg::ADR_LVL, 8'h00);
        chk(fifo_flush, 1'h0);
        wr(6'h3F, 8'hFF);
        rd_chk(rpr_pkg::ADR_IEN, mdl_ien);
        for (int i = 0; i < 4; i++) begin
            wr(rpr_pkg::ADR_TXC, 8'(i));
            @(posedge ref_clk);
            chk({driver2_on, driver1_on, tx_soft_sleep_request_bit}, {i[1:0], ~&i[1:0]});
        end
        // Soft sleep: outputs freeze, inputs and registers live, slow wake
        pin_out_req <= rnd();
        @(posedge ref_clk);
        wr(rpr_pkg::ADR_CMD, 8'h10);
        repeat (3) @(posedge ref_clk);
        #1;
        snap = pin_out;
        chk(core_active, 1'h0);
        pin_out_req <= ~pin_out_req;
        pin_in <= rnd();
        repeat (4) @(posedge ref_clk);
        chk({pin_out, pin_in_clean}, {snap, pin_in});
        rd_chk(rpr_pkg::ADR_IEN, mdl_ien);
        wr(rpr_pkg::ADR_CMD, 8'h00);
        rd_chk(rpr_pkg::ADR_CMD, 8'h10);
        n = 0;
        while (!core_active && n < 1500) begin
            @(posedge ref_clk);
            n++;
        end
        tmo(n >= 1500);
        chk(n + 4 >= 1024, 1);
        rd_chk(rpr_pkg::ADR_CMD, 8'h00);
        chk(irq_enable, mdl_ien);
        // A short glitch is ignored; a long low takes the part down
        host_u.pin(1'h0);
        repeat (2) @(posedge ref_clk);
        host_u.pin(1'h1);
        repeat (8) @(posedge ref_clk);
        #1;
        chk(hard_soft_sleep_request_bit, 1'h0);
        snap = pin_out;
        host_u.pin(1'h0);
        repeat (25) @(posedge ref_clk);
        pin_out_req <= ~pin_out_req;
        pin_in <= rnd();
        wr(rpr_pkg::ADR_IEN, ~mdl_ien);
        repeat (4) @(posedge ref_clk);
        chk({hard_soft_sleep_request_bit, osc_enable, pin_in_clean}, {1'h1, 1'h0, 8'h00});
        chk(pin_out, snap);
        host_u.pin(1'h1);
        host_u.poll(n);
        tmo(!host_u.rd_ok);
        chk(2 * n >= 1020, 1);
        rd_chk(rpr_pkg::ADR_IEN, rpr_pkg::IEN_RST);
        conclude();
    end
endmodule // tb_top
